// ### inc/mms_pkg.sv
/*
 * Package for the move, multiply and stack instruction group:
 * widths, opcode patterns, reset values, phase and operation enums,
 * the status flag and file port carriers, and the opcode decoder.
 * Assumes a 16-bit instruction word and a 12-bit data address space.
 */
package mms_pkg;

    // ==========================================================
    // widths and sizes
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int PC_W = 21;
    localparam int BANK_W = 4;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 4;

    // ==========================================================
    // timing: one clock per quarter, four quarters per instruction
    localparam int CLK_PERIOD_NS = 50;
    localparam int QUARTERS_PER_INSTR = 4;
    localparam int INSTR_PERIOD_NS = CLK_PERIOD_NS * QUARTERS_PER_INSTR;

    // ==========================================================
    // opcode patterns
    localparam logic [7:0] OPC8_LOAD_LIT = 8'h0E;
    localparam logic [7:0] OPC8_MUL_LIT = 8'h0D;
    localparam logic [6:0] OPC7_MUL_FILE = 7'h01;
    localparam logic [6:0] OPC7_STORE = 7'h37;
    localparam logic [6:0] OPC7_NEGATE = 7'h36;
    localparam logic [15:0] OPC_POP = 16'h0006;
    localparam logic [15:0] OPC_PUSH = 16'h0005;
    localparam logic [15:0] OPC_IDLE = 16'h0000;
    localparam logic [3:0] OPC4_IDLE_ALT = 4'hF;

    // ==========================================================
    // addressing constants and field positions
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [BANK_W-1:0] ACCESS_BANK = 4'h0;
    localparam int ACCESS_BIT = 8;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [SP_W-1:0] SP_ONE = 4'h1;
    localparam logic [SP_W-1:0] SP_FULL = 4'h8;

    // ==========================================================
    // reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PROD_RESET = 8'h00;
    localparam logic [SP_W-1:0] SP_RESET = 4'h0;
    localparam logic [PC_W-1:0] STACK_RESET = 21'h000000;

    // ==========================================================
    // types
    typedef enum {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mms_phase_t;

    typedef enum {
        OP_IDLE, OP_LOAD_LIT, OP_STORE, OP_MUL_LIT, OP_MUL_FILE,
        OP_NEGATE, OP_POP, OP_PUSH, OP_FOREIGN
    } mms_op_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } mms_status_t;

    localparam mms_status_t STATUS_RESET = 5'h00;

    typedef struct packed {
        logic q1;
        logic q2;
        logic q3;
        logic q4;
    } mms_quarter_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic we;
        logic [DATA_W-1:0] wdata;
    } mms_file_req_t;

    // ==========================================================
    // opcode decoder
    function automatic mms_op_t mms_decode(input logic [15:0] w);
        mms_op_t op;
        op = OP_FOREIGN;
        if (w == OPC_IDLE || w[15:12] == OPC4_IDLE_ALT) begin
            op = OP_IDLE;
        end else if (w == OPC_POP) begin
            op = OP_POP;
        end else if (w == OPC_PUSH) begin
            op = OP_PUSH;
        end else if (w[15:8] == OPC8_LOAD_LIT) begin
            op = OP_LOAD_LIT;
        end else if (w[15:8] == OPC8_MUL_LIT) begin
            op = OP_MUL_LIT;
        end else if (w[15:9] == OPC7_MUL_FILE) begin
            op = OP_MUL_FILE;
        end else if (w[15:9] == OPC7_STORE) begin
            op = OP_STORE;
        end else if (w[15:9] == OPC7_NEGATE) begin
            op = OP_NEGATE;
        end
        return op;
    endfunction

    // operations that address a file register
    function automatic logic mms_is_file_op(input mms_op_t op);
        return op == OP_STORE || op == OP_MUL_FILE || op == OP_NEGATE;
    endfunction

endpackage

// ### verilog/mms_phase_gen.sv
/*
 * Quarter-cycle generator: rotates Q1..Q4, one clock per quarter,
 * and decodes a one-hot flag for the current quarter from the phase register.
 * Assumes one free-running clock; reset restarts at Q1.
 */
`timescale 1ns/100ps
`default_nettype none

module mms_phase_gen
    import mms_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // current quarter
    output mms_quarter_t quarter_out
);

    mms_phase_t phase_q;

    // ==========================================================
    // quarter rotation
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= PH_Q1;
        end else begin
            case (phase_q)
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                default: phase_q <= PH_Q1;
            endcase
        end
    end

    // one-hot view of the quarter
    always_comb begin
        quarter_out.q1 = phase_q == PH_Q1;
        quarter_out.q2 = phase_q == PH_Q2;
        quarter_out.q3 = phase_q == PH_Q3;
        quarter_out.q4 = phase_q == PH_Q4;
    end

endmodule

`default_nettype wire

// ### verilog/mms_core.sv
/*
 * Execution logic for literal moves into and register moves out of the
 * accumulator, 8x8 unsigned multiply, file negate and return-stack
 * pop and push, with access-bank, bank-select and indexed addressing.
 * Assumes the fetch unit presents each instruction word and its
 * program counter during Q1, and the data file answers a read in the
 * same quarter that the read strobe is high.
 */
`timescale 1ns/100ps
`default_nettype none

module mms_core
    import mms_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // instruction from fetch, taken in Q1
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic [PC_W-1:0] pc_in,
    // addressing context
    input wire logic [BANK_W-1:0] bank_select_reg_in,
    input wire logic ext_set_en_in,
    input wire logic [ADDR_W-1:0] index_base_in,
    // data file port
    output mms_file_req_t file_req_out,
    input wire logic [DATA_W-1:0] file_rdata_in,
    // core state
    output mms_quarter_t quarter_out,
    output logic [DATA_W-1:0] accumulator_out,
    output logic [DATA_W-1:0] product_high_out,
    output logic [DATA_W-1:0] product_low_out,
    output mms_status_t status_out,
    output logic [PC_W-1:0] stack_top_out,
    output logic [SP_W-1:0] stack_level_out
);

    // ==========================================================
    // state
    mms_quarter_t qtr;
    mms_op_t op_q;
    logic [DATA_W-1:0] lit_q;
    logic [PC_W-1:0] pc_q;
    logic [ADDR_W-1:0] addr_q;
    logic rd_q;
    logic [DATA_W-1:0] opnd_q;
    logic [DATA_W-1:0] wdata_q;
    logic [2*DATA_W-1:0] prod_res_q;
    mms_status_t neg_flags_q;
    logic [DATA_W-1:0] acc_q;
    logic [DATA_W-1:0] prod_hi_q;
    logic [DATA_W-1:0] prod_lo_q;
    mms_status_t status_q;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] neg_d;
    logic [DATA_W-1:0] mul_b;

    mms_phase_gen u_phase (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .quarter_out(qtr)
    );

    // ==========================================================
    // decode, Q1
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            op_q <= OP_IDLE;
            lit_q <= ACC_RESET;
            pc_q <= STACK_RESET;
        end else if (qtr.q1) begin
            op_q <= instr_valid_in ? mms_decode(instr_in) : OP_IDLE;
            lit_q <= instr_in[DATA_W-1:0];
            pc_q <= pc_in;
        end
    end

    // effective file address from access bit, bank select and index base
    always_comb begin
        if (!instr_in[ACCESS_BIT]) begin
            if (ext_set_en_in && instr_in[DATA_W-1:0] <= INDEXED_LIMIT) begin
                addr_d = ADDR_W'(index_base_in + {ACCESS_BANK, instr_in[DATA_W-1:0]});
            end else begin
                addr_d = {ACCESS_BANK, instr_in[DATA_W-1:0]};
            end
        end else begin
            addr_d = {bank_select_reg_in, instr_in[DATA_W-1:0]};
        end
    end

    // address held for the whole instruction
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            addr_q <= '0;
        end else if (qtr.q1 && instr_valid_in && mms_is_file_op(mms_decode(instr_in))) begin
            addr_q <= addr_d;
        end
    end

    // ==========================================================
    // operand read, Q2
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rd_q <= 1'b0;
        end else if (qtr.q1) begin
            rd_q <= instr_valid_in && (mms_decode(instr_in) == OP_MUL_FILE
                || mms_decode(instr_in) == OP_NEGATE);
        end else begin
            rd_q <= 1'b0;
        end
    end

    // operand capture at the end of Q2
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            opnd_q <= '0;
        end else if (qtr.q2 && rd_q) begin
            opnd_q <= file_rdata_in;
        end
    end

    // ==========================================================
    // process, Q3
    assign neg_d = DATA_W'(~opnd_q + 8'h01);
    assign mul_b = (op_q == OP_MUL_FILE) ? opnd_q : lit_q;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wdata_q <= '0;
            prod_res_q <= '0;
            neg_flags_q <= STATUS_RESET;
        end else if (qtr.q3) begin
            wdata_q <= (op_q == OP_NEGATE) ? neg_d : acc_q;
            prod_res_q <= {{DATA_W{1'b0}}, acc_q} * {{DATA_W{1'b0}}, mul_b};
            neg_flags_q.n <= neg_d[DATA_W-1];
            neg_flags_q.ov <= opnd_q == 8'h80;
            neg_flags_q.z <= neg_d == 8'h00;
            neg_flags_q.dc <= opnd_q[3:0] == 4'h0;
            neg_flags_q.c <= opnd_q == 8'h00;
        end
    end

    // ==========================================================
    // write, Q4: accumulator
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            acc_q <= ACC_RESET;
        end else if (qtr.q4 && op_q == OP_LOAD_LIT) begin
            acc_q <= lit_q;
        end
    end

    // product pair
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            prod_hi_q <= PROD_RESET;
            prod_lo_q <= PROD_RESET;
        end else if (qtr.q4 && (op_q == OP_MUL_LIT || op_q == OP_MUL_FILE)) begin
            prod_hi_q <= prod_res_q[2*DATA_W-1:DATA_W];
            prod_lo_q <= prod_res_q[DATA_W-1:0];
        end
    end

    // status flags, only the negate writes them
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= STATUS_RESET;
        end else if (qtr.q4 && op_q == OP_NEGATE) begin
            status_q <= neg_flags_q;
        end
    end

    // ==========================================================
    // return stack: push in Q2, pop in Q3
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sp_q <= SP_RESET;
        end else if (qtr.q2 && op_q == OP_PUSH && sp_q != SP_FULL) begin
            sp_q <= sp_q + SP_ONE;
        end else if (qtr.q3 && op_q == OP_POP && sp_q != SP_RESET) begin
            sp_q <= sp_q - SP_ONE;
        end
    end

    // stack storage, older entries stay put below the pointer
    always_ff @(posedge clk_sys_in) begin
        if (qtr.q2 && op_q == OP_PUSH && sp_q != SP_FULL) begin
            stack_mem[sp_q[SP_W-2:0]] <= pc_q + PC_STEP;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        file_req_out.addr = addr_q;
        file_req_out.rd = rd_q;
        file_req_out.we = qtr.q4 && (op_q == OP_STORE || op_q == OP_NEGATE);
        file_req_out.wdata = wdata_q;
    end

    assign quarter_out = qtr;
    assign accumulator_out = acc_q;
    assign product_high_out = prod_hi_q;
    assign product_low_out = prod_lo_q;
    assign status_out = status_q;
    assign stack_level_out = sp_q;
    assign stack_top_out = (sp_q == SP_RESET) ? STACK_RESET
        : stack_mem[3'(sp_q - SP_ONE)];

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    quarter_rotation_a: assert property (
        qtr.q1 |=> qtr.q2 ##1 qtr.q3 ##1 qtr.q4 ##1 qtr.q1)
        else $error("quarter sequence broken");

    literal_load_a: assert property ((qtr.q4 && op_q == OP_LOAD_LIT)
        |=> acc_q == $past(lit_q) && status_q == $past(status_q))
        else $error("literal load wrong");

    store_write_a: assert property ((qtr.q4 && op_q == OP_STORE)
        |-> file_req_out.we && file_req_out.wdata == acc_q ##1 $stable(status_q))
        else $error("store write wrong");

    access_bank_a: assert property ((qtr.q1 && instr_valid_in && !instr_in[ACCESS_BIT]
        && !ext_set_en_in && mms_is_file_op(mms_decode(instr_in)))
        |=> addr_q == {ACCESS_BANK, $past(instr_in[DATA_W-1:0])})
        else $error("access bank address wrong");

    bank_select_a: assert property ((qtr.q1 && instr_valid_in && instr_in[ACCESS_BIT]
        && mms_is_file_op(mms_decode(instr_in)))
        |=> addr_q[ADDR_W-1:DATA_W] == $past(bank_select_reg_in))
        else $error("bank select address wrong");

    indexed_mode_a: assert property ((qtr.q1 && instr_valid_in && !instr_in[ACCESS_BIT]
        && ext_set_en_in && instr_in[DATA_W-1:0] <= INDEXED_LIMIT
        && mms_is_file_op(mms_decode(instr_in)))
        |=> addr_q == ADDR_W'($past(index_base_in) + $past(instr_in[DATA_W-1:0])))
        else $error("indexed address wrong");

    multiply_product_a: assert property (
        (qtr.q3 && (op_q == OP_MUL_LIT || op_q == OP_MUL_FILE))
        |=> ##1 {prod_hi_q, prod_lo_q} == $past(acc_q, 2) * $past(mul_b, 2)
        && acc_q == $past(acc_q, 2) && status_q == $past(status_q, 2))
        else $error("product wrong");

    negate_result_a: assert property ((qtr.q2 && op_q == OP_NEGATE && rd_q)
        ##2 qtr.q4 |-> file_req_out.we && file_req_out.wdata == 8'(-$past(file_rdata_in, 2)))
        else $error("negate result wrong");

    negate_flags_a: assert property ((qtr.q4 && op_q == OP_NEGATE)
        |=> status_q.z == ($past(file_req_out.wdata) == 8'h00)
        && status_q.n == $past(file_req_out.wdata[DATA_W-1]))
        else $error("negate flags wrong");

    stack_pop_a: assert property ((qtr.q3 && op_q == OP_POP && sp_q != SP_RESET)
        |=> sp_q == SP_W'($past(sp_q) - SP_ONE))
        else $error("pop did not drop level");

    stack_push_a: assert property ((qtr.q2 && op_q == OP_PUSH && sp_q != SP_FULL)
        |=> stack_top_out == PC_W'($past(pc_q) + PC_STEP))
        else $error("push top wrong");

    // idle slot: no read, no stack move, no write, no register change at its end
    idle_quiet_a: assert property ((qtr.q2 && op_q == OP_IDLE)
        |-> !rd_q ##1 $stable(sp_q) ##1 !file_req_out.we && $stable(sp_q)
        ##1 $stable(acc_q) && $stable(status_q) && $stable(prod_hi_q) && $stable(prod_lo_q))
        else $error("idle changed state");

    read_quarter_a: assert property (file_req_out.rd |-> qtr.q2)
        else $error("read outside second quarter");

endmodule

`default_nettype wire

// ### bench/mms_file_model.sv
/*
 * Data file partner for the core: 4096 bytes, answers a read in the
 * cycle that the read strobe is high, takes a write at the edge that
 * ends the write cycle.
 * Assumes the testbench may preload or peek the array by hierarchy.
 */
`timescale 1ns/100ps
`default_nettype none

module mms_file_model
    import mms_pkg::*;
(
    // clock
    input wire logic clk_sys_in,
    // core request and read answer
    input wire mms_file_req_t file_req_in,
    output logic [DATA_W-1:0] file_rdata_out
);
    // ==========================================================
    // storage
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last_q;

    // clear the array so reads never return unknowns
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] = 8'h00;
        end
        last_q = 8'h00;
    end

    // answer only while read is high, scrambled otherwise
    assign file_rdata_out = file_req_in.rd ? mem[file_req_in.addr] : ~last_q;

    // remember last answer, store writes
    always @(posedge clk_sys_in) begin
        if (file_req_in.rd) begin
            last_q <= mem[file_req_in.addr];
        end
        if (file_req_in.we) begin
            mem[file_req_in.addr] <= file_req_in.wdata;
        end
    end
endmodule

`default_nettype wire

// ### bench/testbench.sv
/*
 * Self-checking bench for the move, multiply and stack group.
 * Assumes the core takes one word per four quarters, starting in Q1.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench
    import mms_pkg::*;
;
    // ==========================================================
    // signals
    localparam int DRV = 2;
    logic clk_sys_in, rst_in, instr_valid_in, ext_set_en_in;
    logic [15:0] instr_in;
    logic [PC_W-1:0] pc_in, stack_top;
    logic [BANK_W-1:0] bank_select_reg_in;
    logic [ADDR_W-1:0] index_base_in, q2_addr;
    mms_file_req_t file_req;
    logic [DATA_W-1:0] file_rdata, accumulator, product_high, product_low, q4_acc;
    mms_quarter_t quarter;
    mms_status_t status;
    logic [SP_W-1:0] stack_level;
    logic q2_rd, q4_we;
    logic [15:0] q4_prod;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    // design and data file
    mms_core dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .pc_in(pc_in), .bank_select_reg_in(bank_select_reg_in),
        .ext_set_en_in(ext_set_en_in), .index_base_in(index_base_in),
        .file_req_out(file_req), .file_rdata_in(file_rdata), .quarter_out(quarter),
        .accumulator_out(accumulator), .product_high_out(product_high),
        .product_low_out(product_low), .status_out(status), .stack_top_out(stack_top),
        .stack_level_out(stack_level));
    mms_file_model file_model (.clk_sys_in(clk_sys_in), .file_req_in(file_req),
        .file_rdata_out(file_rdata));

    // clock and hang limit
    initial clk_sys_in = 1'b0;
    always #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            results();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic results();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    // expected file address for a file opcode
    function automatic logic [ADDR_W-1:0] faddr(input logic a, input logic [7:0] f,
            input logic [3:0] bank_select_reg, input logic ext, input logic [11:0] base);
        if (a) return {bank_select_reg, f};
        if (ext && f <= INDEXED_LIMIT) return base + {4'h0, f};
        return {ACCESS_BANK, f};
    endfunction

    // one instruction over four quarters, port activity captured
    task automatic exec(input logic [15:0] w, input logic [PC_W-1:0] pc = '0,
            input logic [3:0] bank_select_reg = 4'h0, input logic ext = 1'b0, input logic [11:0] base = '0);
        int n;
        n = 0;
        while (quarter.q1 !== 1'b1 && n < 8) begin
            @(posedge clk_sys_in);
            #DRV;
            n++;
        end
        instr_in = w;
        pc_in = pc;
        bank_select_reg_in = bank_select_reg;
        ext_set_en_in = ext;
        index_base_in = base;
        instr_valid_in = 1'b1;
        @(posedge clk_sys_in);
        #DRV;
        instr_valid_in = 1'b0;
        q2_rd = file_req.rd;
        q2_addr = file_req.addr;
        chk(quarter, 4'h4, "quarter after take");
        repeat (2) @(posedge clk_sys_in);
        #DRV;
        q4_we = file_req.we;
        q4_acc = accumulator;
        q4_prod = {product_high, product_low};
        @(posedge clk_sys_in);
        #DRV;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_stack();
        exec(OPC_PUSH, 21'h003458);
        chk(stack_top, 21'h00345A, "push top");
        exec(OPC_PUSH, 21'h000124);
        chk(stack_top, 21'h000126, "second push top");
        chk(stack_level, 4'h2, "push level");
        exec(OPC_POP);
        chk(stack_top, 21'h00345A, "pop top");
        chk(stack_level, 4'h1, "pop level");
        exec(OPC_POP);
        chk(stack_level, 4'h0, "pop to empty");
        exec(OPC_POP);
        chk(stack_level, 4'h0, "pop on empty");
        chk(stack_top, 21'h000000, "empty top");
    endtask

    task automatic neg_case(input logic [7:0] v);
        logic [7:0] r;
        mms_status_t e;
        file_model.mem[12'h2C0] = v;
        r = ~v + 8'h01;
        e.n = r[7];
        e.ov = (v == 8'h80);
        e.z = (r == 8'h00);
        e.dc = (v[3:0] == 4'h0);
        e.c = (v == 8'h00);
        exec({OPC7_NEGATE, 1'b1, 8'hC0}, '0, 4'h2);
        chk(q2_rd, 1'b1, "negate read");
        chk(q4_we, 1'b1, "negate write");
        chk(file_model.mem[12'h2C0], r, "negate result");
        chk(status, e, "negate flags");
    endtask

    task automatic t_load();
        mms_status_t st;
        st = status;
        exec({OPC8_LOAD_LIT, 8'h5A});
        chk(accumulator, 8'h5A, "load value");
        chk(status, st, "load flags");
        chk(q4_we, 1'b0, "load writes file");
    endtask

    task automatic t_mul_lit();
        logic [7:0] wa [4] = '{8'hE2, 8'hFF, 8'h37, 8'h01};
        logic [7:0] ka [4] = '{8'hC4, 8'hFF, 8'h00, 8'h80};
        logic [15:0] old;
        mms_status_t st;
        for (int i = 0; i < 4; i++) begin
            exec({OPC8_LOAD_LIT, wa[i]});
            st = status;
            old = {product_high, product_low};
            exec({OPC8_MUL_LIT, ka[i]});
            chk({product_high, product_low}, {8'h00, wa[i]} * {8'h00, ka[i]}, "mul lit");
            chk(accumulator, wa[i], "mul lit acc");
            chk(status, st, "mul lit flags");
            chk(q4_prod, old, "product early");
            chk(q4_acc, wa[i], "acc in Q4");
        end
    endtask

    task automatic mulf_case(input logic a, input logic [7:0] f, input logic [3:0] bank_select_reg,
            input logic ext, input logic [11:0] base, input logic [7:0] wv, input logic [7:0] fv);
        logic [ADDR_W-1:0] ad;
        ad = faddr(a, f, bank_select_reg, ext, base);
        file_model.mem[ad] = fv;
        exec({OPC8_LOAD_LIT, wv});
        exec({OPC7_MUL_FILE, a, f}, '0, bank_select_reg, ext, base);
        chk(q2_rd, 1'b1, "mul file read");
        chk(q2_addr, ad, "mul file addr");
        chk({product_high, product_low}, {8'h00, wv} * {8'h00, fv}, "mul file");
        chk(accumulator, wv, "mul file acc");
        chk(file_model.mem[ad], fv, "mul file operand");
        chk(q4_we, 1'b0, "mul file write");
    endtask

    task automatic store_case(input logic a, input logic [7:0] f, input logic [3:0] bank_select_reg,
            input logic ext, input logic [11:0] base, input logic [7:0] wv);
        logic [ADDR_W-1:0] ad;
        mms_status_t st;
        ad = faddr(a, f, bank_select_reg, ext, base);
        file_model.mem[ad] = ~wv;
        exec({OPC8_LOAD_LIT, wv});
        st = status;
        exec({OPC7_STORE, a, f}, '0, bank_select_reg, ext, base);
        chk(file_model.mem[ad], wv, "store data");
        chk(q4_we, 1'b1, "store strobe");
        chk(status, st, "store flags");
    endtask

    task automatic t_idle();
        logic [15:0] prod;
        mms_status_t st;
        prod = {product_high, product_low};
        st = status;
        exec(OPC_IDLE);
        chk(q4_we, 1'b0, "idle write");
        exec(16'hF123);
        chk(q4_we, 1'b0, "idle alt write");
        exec(16'h0100);
        chk(q4_we, 1'b0, "foreign write");
        chk(q2_rd, 1'b0, "foreign read");
        instr_in = {OPC8_LOAD_LIT, 8'hEE};
        repeat (4) @(posedge clk_sys_in);
        #DRV;
        chk(accumulator, 8'h5A, "idle acc");
        chk({product_high, product_low}, prod, "idle product");
        chk(status, st, "idle flags");
        chk(stack_level, 4'h0, "idle stack");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_in = 1'b1;
        instr_valid_in = 1'b0;
        ext_set_en_in = 1'b0;
        instr_in = 16'h0000;
        pc_in = '0;
        bank_select_reg_in = 4'h0;
        index_base_in = '0;
        repeat (16) @(posedge clk_sys_in);
        #DRV;
        rst_in = 1'b0;
        t_stack();
        neg_case(8'h3A);
        neg_case(8'h00);
        neg_case(8'h80);
        neg_case(8'hF0);
        t_mul_lit();
        mulf_case(1'b1, 8'hB5, 4'h3, 1'b0, 12'h000, 8'hC4, 8'hB5);
        mulf_case(1'b0, 8'h20, 4'h9, 1'b1, 12'h300, 8'h07, 8'h10);
        mulf_case(1'b0, 8'h80, 4'h9, 1'b1, 12'h300, 8'hFF, 8'h02);
        store_case(1'b1, 8'hFF, 4'hF, 1'b0, 12'h000, 8'h11);
        store_case(1'b0, 8'hA0, 4'h7, 1'b1, 12'h200, 8'h22);
        store_case(1'b0, 8'h5F, 4'h7, 1'b1, 12'h200, 8'h33);
        store_case(1'b0, 8'h60, 4'h7, 1'b1, 12'h200, 8'h44);
        store_case(1'b0, 8'h10, 4'h7, 1'b0, 12'h200, 8'h55);
        store_case(1'b0, 8'h5F, 4'h7, 1'b1, 12'hFF0, 8'h66);
        t_load();
        t_idle();
        results();
    end
endmodule

`default_nettype wire
